// >>> common/adsf_consts.svh
// constants shared by both ends of the converter serial link
// assumes pclk at 100 MHz; cycle counts are in pclk cycles, frame lengths and edge numbers in sclk edges
`ifndef ADSF_CONSTS_SVH
`define ADSF_CONSTS_SVH

`define ADSF_PCLK_MHZ        100
`define ADSF_CONV_TIME_NS    10000
`define ADSF_CONV_CYCLES     ((`ADSF_CONV_TIME_NS * `ADSF_PCLK_MHZ) / 1000)
`define ADSF_HOST_HALF       4

`define ADSF_CTRL_W          8
`define ADSF_RES_W           12
`define ADSF_OUT_W           16
`define ADSF_SEL_MSB         7
`define ADSF_SEL_LSB         4
`define ADSF_LEN_MSB         3
`define ADSF_LEN_LSB         2
`define ADSF_LBF_BIT         1
`define ADSF_SGN_BIT         0
`define ADSF_SAMPLE_EDGE     5'h04
`define ADSF_CTRL_BITS       4'h8

`define ADSF_SEL_LAST_AIN    4'hA
`define ADSF_SEL_MID         4'hB
`define ADSF_SEL_LOREF       4'hC
`define ADSF_SEL_HIREF       4'hD
`define ADSF_SEL_PDOWN       4'hE
`define ADSF_VAL_MID         12'h800
`define ADSF_VAL_LOREF       12'h000
`define ADSF_VAL_HIREF       12'hFFF
`define ADSF_SIGN_FLIP       12'h800

`define ADSF_LEN_CODE_8      2'h1
`define ADSF_LEN_CODE_16     2'h3
`define ADSF_LEN_8           5'h08
`define ADSF_LEN_12          5'h0C
`define ADSF_LEN_16          5'h10

`define ADSF_REG_CTRL        8'h00
`define ADSF_REG_STATUS      8'h04
`define ADSF_REG_RESULT      8'h08
`define ADSF_CTRL_START_BIT  8
`define ADSF_CTRL_RESET      8'h00

`endif

// >>> common/adsf_pkg.sv
// types shared by both ends of the converter serial link
// assumes adsf_consts.svh for all numeric constants
package adsf_pkg;

  typedef enum logic [2:0] {
    ADSF_H_IDLE  = 3'b000,
    ADSF_H_WEOC  = 3'b001,
    ADSF_H_LEAD  = 3'b010,
    ADSF_H_LO    = 3'b011,
    ADSF_H_HI    = 3'b100,
    ADSF_H_DRAIN = 3'b101
  } adsf_host_st_t;

  typedef logic [4:0] adsf_len_t;

endpackage

// >>> common/adsf_link_if.sv
// serial link between host and converter framing logic
// no tri-state here: dout is qualified by dout_oe for the bench
`timescale 1ns/1ps
interface adsf_link_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic dout_oe;
  logic eoc;

  modport dev (
    input  cs_n,
    input  sclk,
    input  din,
    output dout,
    output dout_oe,
    output eoc
  );

  modport host (
    output cs_n,
    output sclk,
    output din,
    input  dout,
    input  dout_oe,
    input  eoc
  );
endinterface

// >>> rtl/adsf_dev.sv
// converter end: control word capture, framing, conversion pacing, result shift-out
// assumes the link pins are asynchronous to pclk and are synchronised here
//
// Function
// - last falling edge ends transfer, starts conversion
// - finished conversion loads output shift register
// - result leaves during the following transfer
// - capture control word while shifting previous result
// - control word MSB first, taken on rising
// - upper nibble 0..10 selects analog input
// - 11..14 select test voltages or power-down
// - selection applies to the following conversion
// - length bits frame the same transfer
// - length 00 or 10 means 12 bits
// - host gives exactly 12 clocks then
// - 12-bit: convert after twelfth falling edge
// - length 11: 16 bits, four zero pads
// - host gives exactly 16 clocks then
// - 16-bit: convert after sixteenth falling edge
// - host should prefer 12-bit length
// - length 01: 8 bits, low four dropped
// - bit 1 picks order, from next transfer
// - bit 0 picks signed format, this conversion
// - sampling begins on fourth falling edge
`timescale 1ns/1ps
`include "adsf_consts.svh"

module adsf_dev
  import adsf_pkg::*;
#(
  parameter int CONV_CYCLES = `ADSF_CONV_CYCLES
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  adsf_link_if.dev                    link,
  input  wire logic [`ADSF_RES_W-1:0] conv_value,
  output logic      [3:0]             input_sel,
  output logic                        sampling,
  output logic                        converting,
  output logic                        powered_down
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] sclk_s_q;
  logic [1:0] cs_s_q;
  logic [1:0] din_s_q;
  logic       sclk_last_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_s_q    <= 2'h0;
      cs_s_q      <= 2'h3;
      din_s_q     <= 2'h0;
      sclk_last_q <= 1'b0;
    end else begin
      sclk_s_q    <= {sclk_s_q[0], link.sclk};
      cs_s_q      <= {cs_s_q[0], link.cs_n};
      din_s_q     <= {din_s_q[0], link.din};
      sclk_last_q <= sclk_s_q[1];
    end
  end

  // ****************************************
  // framing
  // ****************************************
  logic [`ADSF_CTRL_W-1:0] ctrl_q;
  logic [`ADSF_CTRL_W-1:0] ctrl_d;
  logic [3:0]              rise_cnt_q;
  logic [3:0]              rise_cnt_d;
  logic [4:0]              fall_cnt_q;
  logic [4:0]              fall_cnt_d;
  logic                    conv_q;
  logic [15:0]             conv_cnt_q;
  logic [`ADSF_OUT_W-1:0]  shift_q;
  logic                    lbf_q;
  logic                    sgn_q;
  logic [3:0]              sel_q;
  logic                    samp_q;
  logic                    pd_q;
  logic                    eoc_q;
  logic                    dout_q;
  logic                    oe_q;

  wire        selected  = ~cs_s_q[1];
  wire        rise      = selected & sclk_s_q[1] & ~sclk_last_q & ~conv_q;
  wire        fall      = selected & ~sclk_s_q[1] & sclk_last_q & ~conv_q;
  wire        take_bit  = rise & (rise_cnt_q < `ADSF_CTRL_BITS);
  wire [4:0]  fall_next = fall_cnt_q + 5'h01;
  wire [1:0]  len_code  = ctrl_q[`ADSF_LEN_MSB:`ADSF_LEN_LSB];
  // length is read only from the eighth edge on, once the whole word is in
  wire adsf_len_t frame_len = (len_code == `ADSF_LEN_CODE_8)  ? `ADSF_LEN_8  :
                              (len_code == `ADSF_LEN_CODE_16) ? `ADSF_LEN_16 :
                                                                `ADSF_LEN_12;
  wire        last_fall = fall & (fall_next >= `ADSF_LEN_8)
                               & (fall_next == frame_len);
  wire        conv_done = conv_q & (conv_cnt_q == 16'(CONV_CYCLES - 1));

  // ****************************************
  // result formatting
  // ****************************************
  wire [3:0]  cur_sel   = ctrl_q[`ADSF_SEL_MSB:`ADSF_SEL_LSB];
  logic [`ADSF_RES_W-1:0] raw;

  always_comb begin
    unique case (sel_q)
      `ADSF_SEL_MID:   raw = `ADSF_VAL_MID;
      `ADSF_SEL_LOREF: raw = `ADSF_VAL_LOREF;
      `ADSF_SEL_HIREF: raw = `ADSF_VAL_HIREF;
      `ADSF_SEL_PDOWN: raw = `ADSF_VAL_LOREF;
      default:         raw = (sel_q <= `ADSF_SEL_LAST_AIN) ? conv_value : 12'h000;
    endcase
  end

  wire [`ADSF_RES_W-1:0] fmt = sgn_q ? (raw ^ `ADSF_SIGN_FLIP) : raw;
  // msb-justified; 8-bit frames simply stop before the low nibble
  wire [`ADSF_OUT_W-1:0] msb_word = {fmt, 4'h0};

  // reverses the first n bits of the frame for low-bit-first output
  function automatic logic [`ADSF_OUT_W-1:0] reverse_frame(
    input logic [`ADSF_OUT_W-1:0] w,
    input adsf_len_t              n
  );
    logic [`ADSF_OUT_W-1:0] r;
    r = 16'h0000;
    for (int i = 0; i < `ADSF_OUT_W; i++) begin
      if (i < int'(n)) begin
        r[`ADSF_OUT_W-1-i] = w[`ADSF_OUT_W-int'(n)+i];
      end
    end
    return r;
  endfunction

  adsf_len_t out_len_q;
  wire [`ADSF_OUT_W-1:0] load_word = lbf_q ? reverse_frame(msb_word, out_len_q)
                                           : msb_word;

  assign ctrl_d     = take_bit ? {ctrl_q[`ADSF_CTRL_W-2:0], din_s_q[1]} : ctrl_q;
  assign rise_cnt_d = take_bit ? rise_cnt_q + 4'h1 : rise_cnt_q;
  assign fall_cnt_d = fall ? fall_next : fall_cnt_q;

  // ****************************************
  // state
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q     <= `ADSF_CTRL_RESET;
      rise_cnt_q <= 4'h0;
      fall_cnt_q <= 5'h00;
      conv_q     <= 1'b0;
      conv_cnt_q <= 16'h0000;
      shift_q    <= 16'h0000;
      lbf_q      <= 1'b0;
      sgn_q      <= 1'b0;
      sel_q      <= 4'h0;
      out_len_q  <= `ADSF_LEN_12;
      samp_q     <= 1'b0;
      pd_q       <= 1'b0;
      eoc_q      <= 1'b1;
    end else if (!selected && !conv_q) begin
      // deselect between conversions restarts framing, keeps the result
      rise_cnt_q <= 4'h0;
      fall_cnt_q <= 5'h00;
      samp_q     <= 1'b0;
    end else if (last_fall) begin
      conv_q     <= 1'b1;
      conv_cnt_q <= 16'h0000;
      eoc_q      <= 1'b0;
      samp_q     <= 1'b0;
      rise_cnt_q <= 4'h0;
      fall_cnt_q <= 5'h00;
      sel_q      <= cur_sel;
      pd_q       <= (cur_sel == `ADSF_SEL_PDOWN);
      out_len_q  <= frame_len;
      lbf_q      <= ctrl_q[`ADSF_LBF_BIT];
      sgn_q      <= ctrl_q[`ADSF_SGN_BIT];
      shift_q    <= {shift_q[`ADSF_OUT_W-2:0], 1'b0};
    end else if (conv_q) begin
      conv_cnt_q <= conv_cnt_q + 16'h0001;
      if (conv_done) begin
        conv_q  <= 1'b0;
        eoc_q   <= 1'b1;
        shift_q <= load_word;
      end
    end else begin
      ctrl_q     <= ctrl_d;
      rise_cnt_q <= rise_cnt_d;
      fall_cnt_q <= fall_cnt_d;
      if (fall && fall_next == `ADSF_SAMPLE_EDGE) begin
        samp_q <= 1'b1;
      end
      if (fall) begin
        shift_q <= {shift_q[`ADSF_OUT_W-2:0], 1'b0};
      end
    end
  end

  // output is forced low while converting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout_q <= 1'b0;
      oe_q   <= 1'b0;
    end else begin
      dout_q <= shift_q[`ADSF_OUT_W-1] & ~conv_q;
      oe_q   <= selected;
    end
  end

  assign link.dout    = dout_q;
  assign link.dout_oe = oe_q;
  assign link.eoc     = eoc_q;
  assign input_sel    = sel_q;
  assign sampling     = samp_q;
  assign converting   = conv_q;
  assign powered_down = pd_q;

endmodule

// >>> rtl/adsf_host.sv
// host end: apb-programmed serial master that frames one transfer per start
// assumes the converter's dout and eoc are asynchronous and synchronises them
`timescale 1ns/1ps
`include "adsf_consts.svh"

module adsf_host
  import adsf_pkg::*;
#(
  parameter int HALF = `ADSF_HOST_HALF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  adsf_link_if.host        link
);

  // ****************************************
  // apb slave
  // ****************************************
  logic [7:0]           ctrl_q;
  logic [15:0]          rx_q;
  logic [15:0]          result_q;
  logic                 done_q;
  logic [31:0]          prdata_q;
  logic                 pready_q;
  logic                 pslverr_q;
  logic [1:0]           eoc_s_q;
  logic [1:0]           dout_s_q;
  adsf_host_st_t        st_q;
  adsf_host_st_t        st_d;

  wire setup     = psel & ~penable;
  wire hit_ctrl  = (paddr == `ADSF_REG_CTRL);
  wire hit_stat  = (paddr == `ADSF_REG_STATUS);
  wire hit_res   = (paddr == `ADSF_REG_RESULT);
  wire mapped    = hit_ctrl | hit_stat | hit_res;
  wire busy      = (st_q != ADSF_H_IDLE);
  wire wr_ctrl   = psel & penable & pready_q & pwrite & hit_ctrl;
  wire start     = wr_ctrl & pwdata[`ADSF_CTRL_START_BIT] & ~busy;
  wire [31:0] rd = hit_ctrl ? {24'h000000, ctrl_q} :
                   hit_stat ? {29'h00000000, done_q, eoc_s_q[1], busy} :
                   hit_res  ? {16'h0000, result_q} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
      prdata_q  <= setup ? rd : 32'h00000000;
    end
  end

  // ****************************************
  // serial sequencer
  // ****************************************
  logic [7:0]  tx_q;
  logic [4:0]  bit_q;
  logic [7:0]  tmr_q;
  logic        sclk_q;
  logic        cs_n_q;
  logic        din_q;

  wire [1:0]  len_code = ctrl_q[`ADSF_LEN_MSB:`ADSF_LEN_LSB];
  // host keeps the clock count to the length it sends, so framing stays in step
  wire adsf_len_t nclk = (len_code == `ADSF_LEN_CODE_8)  ? `ADSF_LEN_8  :
                         (len_code == `ADSF_LEN_CODE_16) ? `ADSF_LEN_16 :
                                                           `ADSF_LEN_12;
  wire        tmr_end  = (tmr_q == 8'(HALF - 1));
  wire        last_bit = (bit_q + 5'h01 == nclk);
  // a bit needs about seven pclk to come back through both synchronisers,
  // so it is taken at the end of the high phase, before the device shifts
  wire [15:0] rx_d     = {rx_q[14:0], dout_s_q[1]};

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ADSF_H_IDLE:  if (start) st_d = ADSF_H_WEOC;
      ADSF_H_WEOC:  if (eoc_s_q[1]) st_d = ADSF_H_LEAD;
      ADSF_H_LEAD:  if (tmr_end) st_d = ADSF_H_LO;
      ADSF_H_LO:    if (tmr_end) st_d = ADSF_H_HI;
      ADSF_H_HI:    if (tmr_end) st_d = last_bit ? ADSF_H_DRAIN : ADSF_H_LO;
      ADSF_H_DRAIN: if (!eoc_s_q[1]) st_d = ADSF_H_IDLE;
      default:      st_d = ADSF_H_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eoc_s_q  <= 2'h0;
      dout_s_q <= 2'h0;
    end else begin
      eoc_s_q  <= {eoc_s_q[0], link.eoc};
      dout_s_q <= {dout_s_q[0], link.dout};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q     <= ADSF_H_IDLE;
      ctrl_q   <= `ADSF_CTRL_RESET;
      tx_q     <= 8'h00;
      rx_q     <= 16'h0000;
      result_q <= 16'h0000;
      done_q   <= 1'b0;
      bit_q    <= 5'h00;
      tmr_q    <= 8'h00;
      sclk_q   <= 1'b0;
      cs_n_q   <= 1'b1;
      din_q    <= 1'b0;
    end else begin
      st_q  <= st_d;
      tmr_q <= (st_d != st_q || tmr_end) ? 8'h00 : tmr_q + 8'h01;
      if (wr_ctrl && !busy) begin
        ctrl_q <= pwdata[7:0];
        tx_q   <= pwdata[7:0];
        done_q <= 1'b0;
        bit_q  <= 5'h00;
      end
      if (st_q == ADSF_H_WEOC && st_d == ADSF_H_LEAD) begin
        cs_n_q <= 1'b0;
      end
      if (st_d == ADSF_H_LO && st_q != ADSF_H_LO) begin
        sclk_q <= 1'b0;
        din_q  <= tx_q[7];
        tx_q   <= {tx_q[6:0], 1'b0};
      end
      if (st_q == ADSF_H_LO && st_d == ADSF_H_HI) begin
        sclk_q <= 1'b1;
      end
      if (st_q == ADSF_H_HI && tmr_end) begin
        sclk_q <= 1'b0;
        bit_q  <= bit_q + 5'h01;
        rx_q   <= rx_d;
        if (last_bit) begin
          din_q    <= 1'b0;
          result_q <= rx_d;
          done_q   <= 1'b1;
        end
      end
      // select stays low until the converter has seen the last fall
      if (st_q == ADSF_H_DRAIN && st_d == ADSF_H_IDLE) begin
        cs_n_q <= 1'b1;
      end
    end
  end

  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign link.cs_n = cs_n_q;
  assign link.sclk = sclk_q;
  assign link.din  = din_q;

endmodule

// >>> dv/adsf_link_chk.sv
// checker for the converter serial link; sees only the interface wires
// assumes both ends run on pclk and sclk half periods of at least 6 pclk
`timescale 1ns/1ps
`include "adsf_consts.svh"
module adsf_link_chk
  import adsf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic eoc
);
  // ****************************************
  // frame tracking
  // ****************************************
  logic       sclk_q;
  logic       cs_q;
  logic [7:0] word_q;
  logic [7:0] prev_q;
  logic [4:0] rc_q;
  logic [4:0] fc_q;
  logic       have_q;
  logic       fin_q;
  adsf_len_t  len_w;
  wire        rise_w = sclk & ~sclk_q;
  wire        fall_w = ~sclk & sclk_q;
  wire        last_w = fall_w & ~cs_n & (rc_q >= 5'h08) & (fc_q + 5'h01 == len_w);

  assign len_w = (word_q[3:2] == `ADSF_LEN_CODE_8) ? `ADSF_LEN_8 :
                 (word_q[3:2] == `ADSF_LEN_CODE_16) ? `ADSF_LEN_16 : `ADSF_LEN_12;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {sclk_q, cs_q, word_q, prev_q, rc_q, fc_q, have_q, fin_q} <= {1'h0, 1'h1, 28'h0};
    end else begin
      sclk_q <= sclk;
      cs_q   <= cs_n;
      rc_q   <= cs_n ? 5'h00 : rc_q + {4'h0, rise_w};
      fc_q   <= cs_n ? 5'h00 : fc_q + {4'h0, fall_w};
      if (!cs_n && rise_w && rc_q < 5'h08) word_q <= {word_q[6:0], din};
      if (cs_n && !cs_q) {prev_q, have_q} <= {word_q, 1'h1};
      fin_q  <= last_w | (fin_q & ~(~cs_n & cs_q));
    end
  end

  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_end8;
    last_w && len_w == `ADSF_LEN_8 |-> ##[1:6] !eoc;
  endproperty
  a_end8: assert property (p_end8) else $error("no conversion after 8th fall");
  property p_end12;
    last_w && len_w == `ADSF_LEN_12 |-> ##[1:6] !eoc;
  endproperty
  a_end12: assert property (p_end12) else $error("no conversion after 12th fall");
  property p_end16;
    last_w && len_w == `ADSF_LEN_16 |-> ##[1:6] !eoc;
  endproperty
  a_end16: assert property (p_end16) else $error("no conversion after 16th fall");
  property p_hold;
    !cs_n && fc_q < ((rc_q >= 5'h08) ? len_w : 5'h08) |-> eoc;
  endproperty
  a_hold: assert property (p_hold) else $error("conversion began mid frame");
  property p_fin;
    $fell(eoc) |-> fin_q;
  endproperty
  a_fin: assert property (p_fin) else $error("conversion without a closed frame");
  property p_pad;
    rise_w && !cs_n && have_q && prev_q[3:2] == `ADSF_LEN_CODE_16 && !prev_q[1]
      && rc_q >= 5'h0C |-> !dout;
  endproperty
  a_pad: assert property (p_pad) else $error("16 bit pad not zero");
  property p_zero;
    !eoc && !$past(eoc) |-> !dout;
  endproperty
  a_zero: assert property (p_zero) else $error("output not held low while converting");
  property p_oe;
    $fell(cs_n) |-> ##[1:6] dout_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("output not driven in frame");

  c_len8: cover property (last_w && len_w == `ADSF_LEN_8);
  c_len16: cover property (last_w && len_w == `ADSF_LEN_16);
  c_pad: cover property (rise_w && have_q && prev_q[3:2] == `ADSF_LEN_CODE_16 && rc_q >= 5'h0C);
endmodule

// >>> dv/testbench.sv
// self-checking bench: apb host end wired to the converter end over the link
// assumes a shortened conversion time; expectations come from the word fields
`timescale 1ns/1ps
`include "adsf_consts.svh"
module testbench;
  import adsf_pkg::*;
  // ****************************************
  // set-up
  // ****************************************
  localparam int NFR = 36;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [11:0] conv_value;
  logic [3:0]  input_sel;
  logic        sampling;
  logic        converting;
  logic        powered_down;
  int          err_total;
  int          samples_checked;
  int          seed;

  adsf_link_if link();
  adsf_host #(.HALF(6)) adsf_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link.host));
  adsf_dev #(.CONV_CYCLES(20)) adsf_dev_i (.pclk(pclk), .presetn(presetn),
    .link(link.dev), .conv_value(conv_value), .input_sel(input_sel), .sampling(sampling),
    .converting(converting), .powered_down(powered_down));
  adsf_link_chk adsf_link_chk_i (.pclk(pclk), .presetn(presetn), .cs_n(link.cs_n),
    .sclk(link.sclk), .din(link.din), .dout(link.dout), .dout_oe(link.dout_oe), .eoc(link.eoc));

  initial pclk = 1'h0;
  always #5 pclk = ~pclk;

  function automatic adsf_len_t flen(input logic [7:0] w);
    return (w[3:2] == `ADSF_LEN_CODE_8) ? `ADSF_LEN_8 :
           (w[3:2] == `ADSF_LEN_CODE_16) ? `ADSF_LEN_16 : `ADSF_LEN_12;
  endfunction

  // frame seen by the host for a conversion asked with word w on value v
  function automatic logic [15:0] exp_frame(input logic [7:0] w, input logic [11:0] v,
                                            input adsf_len_t n);
    logic [11:0] c;
    logic [15:0] f;
    logic [15:0] r;
    c = (w[7:4] <= `ADSF_SEL_LAST_AIN) ? v : (w[7:4] == `ADSF_SEL_MID) ? `ADSF_VAL_MID :
        (w[7:4] == `ADSF_SEL_HIREF) ? `ADSF_VAL_HIREF : 12'h000;
    if (w[`ADSF_SGN_BIT]) c = c ^ `ADSF_SIGN_FLIP;
    f = (n == `ADSF_LEN_8) ? {8'h00, c[11:4]} : (n == `ADSF_LEN_16) ? {c, 4'h0} : {4'h0, c};
    r = f;
    for (int k = 0; k < n; k++) r[k] = w[`ADSF_LBF_BIT] ? f[n-1-k] : f[k];
    return r;
  endfunction

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task final_report;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ****************************************
  // bus and frame tasks
  // ****************************************
  // entered just after a rising edge; pready is taken at the rising edge itself
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  task frame(input logic [7:0] w, output logic [15:0] res);
    logic [31:0] r;
    logic        e;
    apb(1'h1, `ADSF_REG_CTRL, {23'h0, 1'h1, w}, r, e);
    do begin
      apb(1'h0, `ADSF_REG_STATUS, 32'h0, r, e);
    end while (r[0] !== 1'h0 || r[2] !== 1'h1);
    check("converting", {31'h0, converting}, 32'h1);
    while (link.eoc !== 1'h1) begin
      @(posedge pclk);
    end
    @(posedge pclk);
    apb(1'h0, `ADSF_REG_RESULT, 32'h0, r, e);
    res = r[15:0];
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [31:0] r;
    logic        e;
    logic [7:0]  w;
    logic [7:0]  pw;
    logic [11:0] pv;
    logic [15:0] res;
    adsf_len_t   n;
    {psel, penable, pwrite, paddr, pwdata, presetn} = 44'h0;
    {err_total, samples_checked, seed, pw, pv} = {64'h0, 32'd367, 20'h0};
    conv_value = 12'h000;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    repeat (4) @(posedge pclk);
    apb(1'h0, 8'h0C, 32'h0, r, e);
    check("unmapped error", {31'h0, e}, 32'h1);
    check("unmapped data", r, 32'h0);
    // sel walks all codes twice; length groups of three leave some same-length pairs
    for (int i = 0; i < NFR; i++) begin
      r = $random(seed);
      w = {i[3:0], 2'(i / 3), r[13:12] & {1'h1, i[3:0] < 4'hE}};
      conv_value <= r[11:0];
      @(posedge pclk);
      frame(w, res);
      n = flen(w);
      if (i > 0 && n == flen(pw))
        check("result", {16'h0, res & (16'hFFFF >> (16 - n))}, {16'h0, exp_frame(pw, pv, n)});
      check("input_sel", {28'h0, input_sel}, {28'h0, w[7:4]});
      check("powered_down", {31'h0, powered_down}, {31'h0, w[7:4] == `ADSF_SEL_PDOWN});
      check("converting", {31'h0, converting}, 32'h0);
      check("sampling", {31'h0, sampling}, 32'h0);
      pw = w;
      pv = conv_value;
    end
    final_report;
  end

  // generous bound: a frame needs well under 800 cycles
  initial begin
    #(NFR * 8000 + 2000);
    err_total++;
    final_report;
  end
endmodule
